// ==== rtl/pkls_scanner.sv ====
// panel key matrix scanner and lamp matrix scanner with fault indicators
// Notes on behaviour
// - read 64 keys as eight commons by eight data lines, one byte each.
// - drive one key common low at a time; sample data only then.
// - whole key common rotation takes 11.68 ms.
// - report a key pressed only when held beyond one host cycle.
// - drive 32 lamps as two independent 4 x 4 matrices.
// - lamp lit only with its common high and data asserted.
// - step four lamp commons in order, 1.28 ms lit per 5.84 ms.
// - emergency indicator follows the emergency stop condition.
// - each link alarm lamp follows its link's communication error.
`timescale 1ns/1ps
module pkls_scanner #(
    parameter int KEY_SLOT_CYC = pkls_pkg::KEY_SLOT_CYC,
    parameter int LAMP_SLOT_CYC = pkls_pkg::LAMP_SLOT_CYC,
    parameter int LAMP_ON_CYC = pkls_pkg::LAMP_ON_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // key matrix pins, active low
    output logic [7:0] key_common_n,
    input wire logic [7:0] key_data_n,
    // key results towards the controller
    output logic [63:0] key_image,
    output logic [63:0] key_pressed,
    output logic key_image_valid,
    // lamp images, matrix a and b
    input wire logic [15:0] lamp_pattern_a,
    input wire logic [15:0] lamp_pattern_b,
    // lamp matrix pins, active high
    output logic [3:0] lamp_common_a,
    output logic [3:0] lamp_data_a,
    output logic [3:0] lamp_common_b,
    output logic [3:0] lamp_data_b,
    // fault conditions
    input wire logic emergency_stop_in,
    input wire logic [3:0] link_error,
    // fault indicators, active high
    output logic emergency_stop_indicator,
    output logic link_alarm_indicator_1,
    output logic link_alarm_indicator_2,
    output logic link_alarm_indicator_3,
    output logic link_alarm_indicator_4
);
    localparam int CW = pkls_pkg::CNT_W;

    logic [CW-1:0] key_cnt_reg;
    logic [CW-1:0] key_cnt_next;
    logic [2:0] key_slot_reg;
    logic [2:0] key_slot_next;
    logic [7:0] key_common_n_reg;
    logic [7:0] key_common_n_next;
    logic [63:0] shadow_reg;
    logic [63:0] shadow_next;
    logic [63:0] image_reg;
    logic [63:0] image_next;
    logic [63:0] pressed_reg;
    logic [63:0] pressed_next;
    logic valid_reg;
    logic valid_next;
    logic key_capture;
    logic [CW-1:0] lamp_cnt_reg;
    logic [CW-1:0] lamp_cnt_next;
    logic [1:0] lamp_slot_reg;
    logic [1:0] lamp_slot_next;
    logic [4:0] fault_reg;
    logic [4:0] fault_next;

    // capture on the last cycle of a slot while its common is still low
    assign key_capture = (key_cnt_reg == CW'(KEY_SLOT_CYC - 1));

    // key scan next state
    always_comb begin
        key_cnt_next = key_cnt_reg + 1'b1;
        key_slot_next = key_slot_reg;
        shadow_next = shadow_reg;
        image_next = image_reg;
        pressed_next = pressed_reg;
        valid_next = 1'b0;
        if (key_capture) begin
            key_cnt_next = '0;
            key_slot_next = key_slot_reg + 3'h1;
            // low data under the low common means pressed
            shadow_next[key_slot_reg * pkls_pkg::KEY_DATA +: pkls_pkg::KEY_DATA] =
                ~key_data_n;
            if (key_slot_reg == 3'(pkls_pkg::KEY_COMMONS - 1)) begin
                image_next = shadow_next;
                // on in two successive rotations before it counts
                pressed_next = shadow_next & image_reg;
                valid_next = 1'b1;
            end
        end
        key_common_n_next = ~(pkls_pkg::KEY_COMMON_ONE << key_slot_next);
    end

    // key scan registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            key_cnt_reg <= '0;
            key_slot_reg <= 3'h0;
            key_common_n_reg <= pkls_pkg::KEY_COMMON_IDLE;
            shadow_reg <= '0;
            image_reg <= '0;
            pressed_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            key_cnt_reg <= key_cnt_next;
            key_slot_reg <= key_slot_next;
            key_common_n_reg <= key_common_n_next;
            shadow_reg <= shadow_next;
            image_reg <= image_next;
            pressed_reg <= pressed_next;
            valid_reg <= valid_next;
        end
    end

    assign key_common_n = key_common_n_reg;
    assign key_image = image_reg;
    assign key_pressed = pressed_reg;
    assign key_image_valid = valid_reg;

    // lamp scan next state
    always_comb begin
        lamp_cnt_next = lamp_cnt_reg + 1'b1;
        lamp_slot_next = lamp_slot_reg;
        if (lamp_cnt_reg == CW'(LAMP_SLOT_CYC - 1)) begin
            lamp_cnt_next = '0;
            lamp_slot_next = lamp_slot_reg + 2'h1;
        end
    end

    // lamp scan registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lamp_cnt_reg <= '0;
            lamp_slot_reg <= 2'h0;
        end else begin
            lamp_cnt_reg <= lamp_cnt_next;
            lamp_slot_reg <= lamp_slot_next;
        end
    end

    // shared timing to both lamp matrices
    pkls_lamp_if tick ();
    assign tick.slot = lamp_slot_reg;
    assign tick.lit = (lamp_cnt_reg < CW'(LAMP_ON_CYC));

    // two independent matrices
    pkls_lamp_matrix u_lamp_a (
        .mclk(mclk),
        .reset(reset),
        .tick(tick),
        .pattern(lamp_pattern_a),
        .lamp_common(lamp_common_a),
        .lamp_data(lamp_data_a)
    );
    pkls_lamp_matrix u_lamp_b (
        .mclk(mclk),
        .reset(reset),
        .tick(tick),
        .pattern(lamp_pattern_b),
        .lamp_common(lamp_common_b),
        .lamp_data(lamp_data_b)
    );

    // fault indicators follow their conditions
    always_comb begin
        fault_next = {link_error, emergency_stop_in};
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fault_reg <= 5'h00;
        end else begin
            fault_reg <= fault_next;
        end
    end

    assign emergency_stop_indicator = fault_reg[0];
    assign link_alarm_indicator_1 = fault_reg[1];
    assign link_alarm_indicator_2 = fault_reg[2];
    assign link_alarm_indicator_3 = fault_reg[3];
    assign link_alarm_indicator_4 = fault_reg[4];

    // checks on the scan behaviour
    // commons are still idle on the first edge after release
    a_key_one_low: assert property (@(posedge mclk) disable iff (reset)
        !$past(reset) |-> $onehot(~key_common_n)) else $error("key commons not one low");
    a_key_sample_low: assert property (@(posedge mclk) disable iff (reset)
        key_capture |-> (key_common_n[key_slot_reg] == 1'b0))
        else $error("key sample without low common");
    a_key_slot_time: assert property (@(posedge mclk) disable iff (reset)
        $changed(key_common_n) && !$past(reset) &&
        $past(key_common_n) != pkls_pkg::KEY_COMMON_IDLE |-> $past(key_capture))
        else $error("key common changed mid slot");
    a_image_latch_end: assert property (@(posedge mclk) disable iff (reset)
        key_image_valid |-> $past(key_slot_reg) == 3'h7 && key_image[63:56] == ~$past(key_data_n))
        else $error("image not latched at rotation end");
    a_pressed_needs_two: assert property (@(posedge mclk) disable iff (reset)
        key_image_valid |-> key_pressed == (key_image & $past(key_image)))
        else $error("pressed key not in image");
    a_lamp_off_time: assert property (@(posedge mclk) disable iff (reset)
        (lamp_cnt_reg == CW'(LAMP_ON_CYC)) |=> (lamp_common_a == 4'h0))
        else $error("lamp lit past on time");
    a_lamp_on_start: assert property (@(posedge mclk) disable iff (reset)
        !reset && (lamp_cnt_reg == '0) |=> (lamp_common_a == (4'h1 << $past(lamp_slot_reg))))
        else $error("lamp common not selected at slot start");
    a_emg_follow: assert property (@(posedge mclk) disable iff (reset)
        !reset |=> emergency_stop_indicator == $past(emergency_stop_in))
        else $error("emergency indicator wrong");
    a_alarm_follow: assert property (@(posedge mclk) disable iff (reset)
        !reset |=> {link_alarm_indicator_4, link_alarm_indicator_3, link_alarm_indicator_2,
        link_alarm_indicator_1} == $past(link_error)) else $error("link alarm wrong");
    a_reset_idle: assert property (@(posedge mclk)
        $past(reset) |-> key_common_n == pkls_pkg::KEY_COMMON_IDLE && key_image == 64'h0)
        else $error("reset state wrong");
    c_rotation_done: cover property (@(posedge mclk) disable iff (reset) key_image_valid);
    c_key_pressed: cover property (@(posedge mclk) disable iff (reset) key_pressed != 64'h0);
    c_lamp_lit: cover property (@(posedge mclk) disable iff (reset) lamp_data_b != 4'h0);
endmodule

// ==== rtl/pkls_pkg.sv ====
// constants shared by the panel key and lamp scanner
package pkls_pkg;
    // system clock rate
    localparam int CLK_MHZ = 40;
    // key matrix shape
    localparam int KEY_COMMONS = 8;
    localparam int KEY_DATA = 8;
    // lamp matrix shape, per matrix
    localparam int LAMP_COMMONS = 4;
    localparam int LAMP_DATA = 4;
    // key common changeover cycle, 11.68 ms
    localparam int KEY_ROTATION_US = 11680;
    // lamp rotation 5.84 ms, each lamp lit 1.28 ms
    localparam int LAMP_ROTATION_US = 5840;
    localparam int LAMP_ON_US = 1280;
    // derived cycle counts
    localparam int KEY_SLOT_CYC = KEY_ROTATION_US * CLK_MHZ / KEY_COMMONS;
    localparam int LAMP_SLOT_CYC = LAMP_ROTATION_US * CLK_MHZ / LAMP_COMMONS;
    localparam int LAMP_ON_CYC = LAMP_ON_US * CLK_MHZ;
    // counter width able to hold the slot counts
    localparam int CNT_W = 17;
    // key common idle level and one-common select patterns
    localparam logic [7:0] KEY_COMMON_IDLE = 8'hff;
    localparam logic [7:0] KEY_COMMON_ONE = 8'h01;
    localparam logic [3:0] LAMP_COMMON_ONE = 4'h1;
endpackage

// ==== rtl/pkls_lamp_if.sv ====
// shared lamp scan timing carried from the scanner to each lamp matrix
`timescale 1ns/1ps
interface pkls_lamp_if;
    logic [1:0] slot;
    logic lit;
    modport src (output slot, output lit);
    modport sink (input slot, input lit);
endinterface

// ==== rtl/pkls_lamp_matrix.sv ====
// one 4 x 4 lamp matrix driver with registered commons and data
`timescale 1ns/1ps
module pkls_lamp_matrix (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // shared scan timing
    pkls_lamp_if.sink tick,
    // lamp image, bit common*4 + data
    input wire logic [15:0] pattern,
    // matrix pins, active high
    output logic [3:0] lamp_common,
    output logic [3:0] lamp_data
);
    logic [3:0] common_reg;
    logic [3:0] common_next;
    logic [3:0] data_reg;
    logic [3:0] data_next;

    // select one common while lit, data only alongside it
    always_comb begin
        common_next = 4'h0;
        data_next = 4'h0;
        if (tick.lit) begin
            common_next = pkls_pkg::LAMP_COMMON_ONE << tick.slot;
            data_next = pattern[tick.slot * pkls_pkg::LAMP_DATA +: pkls_pkg::LAMP_DATA];
        end
    end

    // registers, dark from reset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            common_reg <= 4'h0;
            data_reg <= 4'h0;
        end else begin
            common_reg <= common_next;
            data_reg <= data_next;
        end
    end

    assign lamp_common = common_reg;
    assign lamp_data = data_reg;

    // checks on the lamp pins
    a_lamp_dark_off: assert property (@(posedge mclk) disable iff (reset)
        (lamp_common == 4'h0) |-> (lamp_data == 4'h0)) else $error("lamp data without common");
    a_lamp_one_common: assert property (@(posedge mclk) disable iff (reset)
        $onehot0(lamp_common)) else $error("more than one lamp common high");
endmodule

// ==== verif/pkls_panel_model.sv ====
// far side of the scanner: diode key matrix and two passive lamp matrices
`timescale 1ns/1ps
module pkls_panel_model (
    // key matrix pins and closed contacts, bit common*8 + data
    input wire logic [7:0] key_common_n,
    input wire logic [63:0] key_map,
    output logic [7:0] key_data_n,
    // lamp matrix pins and the lamps that glow, bit common*4 + data
    input wire logic [3:0] lamp_common_a,
    input wire logic [3:0] lamp_data_a,
    input wire logic [3:0] lamp_common_b,
    input wire logic [3:0] lamp_data_b,
    output logic [15:0] lit_a,
    output logic [15:0] lit_b
);
    // closed contact pulls its data low through its diode; pull-ups hold the rest high
    always_comb begin
        key_data_n = 8'hff;
        for (int k = 0; k < 8; k++) begin
            for (int j = 0; j < 8; j++) begin
                if (!key_common_n[k] && key_map[k*8+j]) begin
                    key_data_n[j] = 1'b0;
                end
            end
        end
    end

    // a lamp glows only where its common and its data are both high
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            lit_a[i] = lamp_common_a[i/4] & lamp_data_a[i%4];
            lit_b[i] = lamp_common_b[i/4] & lamp_data_b[i%4];
        end
    end
endmodule

// ==== verif/panel_key_led_scanner_tb.sv ====
// self-checking bench for the panel key and lamp scanner
`timescale 1ns/1ps
module panel_key_led_scanner_tb;
    localparam logic [63:0] KEYS_A = 64'h8001_0000_00c0_0001;
    localparam logic [63:0] KEYS_B = 64'h8000_0300_00c0_0001;
    logic mclk, reset, emergency_stop_in;
    logic [3:0] link_error;
    logic [15:0] lamp_pattern_a, lamp_pattern_b, lit_a, lit_b;
    logic [63:0] key_map, key_image, key_pressed;
    logic [7:0] key_common_n, key_data_n, exp_k;
    logic [3:0] lamp_common_a, lamp_data_a, lamp_common_b, lamp_data_b, exp_c;
    logic key_image_valid, lit;
    logic [4:0] ind;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int rot, sl;
    // rows: {emergency, link errors} then expected {emergency lamp, alarms 4..1}
    logic [9:0] rows [8] = '{10'h000, 10'h210, 10'h021, 10'h042, 10'h084, 10'h108,
        10'h3ff, 10'h000};

    pkls_scanner #(.KEY_SLOT_CYC(8), .LAMP_SLOT_CYC(10), .LAMP_ON_CYC(6)) dut (
        .mclk(mclk), .reset(reset), .key_common_n(key_common_n), .key_data_n(key_data_n),
        .key_image(key_image), .key_pressed(key_pressed), .key_image_valid(key_image_valid),
        .lamp_pattern_a(lamp_pattern_a), .lamp_pattern_b(lamp_pattern_b),
        .lamp_common_a(lamp_common_a), .lamp_data_a(lamp_data_a),
        .lamp_common_b(lamp_common_b), .lamp_data_b(lamp_data_b),
        .emergency_stop_in(emergency_stop_in), .link_error(link_error),
        .emergency_stop_indicator(ind[4]), .link_alarm_indicator_1(ind[0]),
        .link_alarm_indicator_2(ind[1]), .link_alarm_indicator_3(ind[2]),
        .link_alarm_indicator_4(ind[3]));

    pkls_panel_model partner (.key_common_n(key_common_n), .key_map(key_map),
        .key_data_n(key_data_n), .lamp_common_a(lamp_common_a), .lamp_data_a(lamp_data_a),
        .lamp_common_b(lamp_common_b), .lamp_data_b(lamp_data_b), .lit_a(lit_a), .lit_b(lit_b));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // compare one value and count it
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // print counts and verdict, then stop
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // cut a hang short
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            n_errors++;
            test_done();
        end
    end

    // main sequence
    initial begin
        reset = 1'b1;
        key_map = KEYS_A;
        lamp_pattern_a = 16'ha5c3;
        lamp_pattern_b = 16'h5a3c;
        emergency_stop_in = 1'b0;
        link_error = 4'h0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            {emergency_stop_in, link_error} <= rows[i][9:5];
            @(posedge mclk);
            @(negedge mclk);
            chk("indicators", 64'(rows[i][4:0]), 64'(ind));
        end
        $display("test indicators done");
        // reset with a latched image and live faults
        @(posedge mclk);
        {emergency_stop_in, link_error} <= 5'h1f;
        repeat (70) @(posedge mclk);
        reset <= 1'b1;
        @(negedge mclk);
        chk("common_n", 64'hff, 64'(key_common_n));
        chk("image", 64'h0, key_image);
        chk("pressed", 64'h0, key_pressed);
        chk("lamps", 64'h0, {lamp_common_a, lamp_data_a, lamp_common_b, lamp_data_b});
        chk("valid ind", 64'h0, {key_image_valid, ind});
        $display("test reset done");
        repeat (3) @(posedge mclk);
        {emergency_stop_in, link_error} <= 5'h00;
        reset <= 1'b0;
        rot = 0;
        // three key rotations with a key change after the first
        for (int c = 0; c < 200; c++) begin
            @(posedge mclk);
            if (rot == 1) begin
                key_map <= KEYS_B;
            end
            @(negedge mclk);
            // the first slot shows its common one cycle late, while the counter runs
            exp_k = ~(8'h01 << (((c + 1) / 8) % 8));
            chk("common_n", 64'(exp_k), 64'(key_common_n));
            chk("valid", 64'((c + 1) % 64 == 0), 64'(key_image_valid));
            // lamp pins show the counter state of the cycle before
            lit = (c % 10) < 6;
            sl = (c / 10) % 4;
            exp_c = lit ? 4'h1 << sl : 4'h0;
            chk("lamp a", {exp_c, lit ? lamp_pattern_a[sl*4+:4] : 4'h0},
                {lamp_common_a, lamp_data_a});
            chk("lamp b", {exp_c, lit ? lamp_pattern_b[sl*4+:4] : 4'h0},
                {lamp_common_b, lamp_data_b});
            chk("lit", lit ? {lamp_pattern_a, lamp_pattern_b} & {2{16'hf << sl*4}} : 0,
                {lit_a, lit_b});
            if (key_image_valid === 1'b1) begin
                rot++;
                chk("image", rot == 1 ? KEYS_A : KEYS_B, key_image);
                chk("pressed", rot == 1 ? 64'h0 : (rot == 2 ? KEYS_A & KEYS_B : KEYS_B),
                    key_pressed);
            end
        end
        chk("rotations", 64'h3, 64'(rot));
        $display("test scan done");
        test_done();
    end
endmodule
